// >>> bench/cmpc_analog_model.sv
// behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module cmpc_analog_model #(
    parameter int SETTLE_CYCLES = 6
) (
    input wire logic core_clk,
    input wire logic [1:0] comparator_on,
    input wire logic [7:0] reference_level,
    input wire logic reference_source_select,
    input wire logic [11:0] ch0_plus_mv,
    input wire logic [11:0] ch0_minus_mv,
    input wire logic [11:0] ch1_plus_mv,
    output logic [1:0] compare_raw
);
    logic [11:0] ref0_mv;
    logic [11:0] ref1_mv;
    logic [1:0] above;
    int settle_cnt [2];
    // internal reference climbs 50 mV per code, from 50 mV at code zero
    assign ref0_mv = 12'h032 + 12'h032 * {8'h00, reference_level[3:0]};
    assign ref1_mv = 12'h032 + 12'h032 * {8'h00, reference_level[7:4]};
    assign above[0] = ch0_plus_mv > (reference_source_select ? ch0_minus_mv : ref0_mv);
    assign above[1] = ch1_plus_mv > ref1_mv;
    initial compare_raw = 2'h0;
    // an unpowered or settling core has no valid level, so it chatters every cycle
    always @(posedge core_clk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!comparator_on[ch] || settle_cnt[ch] < SETTLE_CYCLES)
                compare_raw[ch] <= ~compare_raw[ch];
            else
                compare_raw[ch] <= above[ch];
            settle_cnt[ch] <= comparator_on[ch] ? settle_cnt[ch] + 1 : 0;
        end
    end
endmodule // cmpc_analog_model

// >>> bench/cmpc_ctrl_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "cmpc_regs.svh"
module cmpc_ctrl_test;
    import cmpc_pkg::*;
    logic core_clk = 1'b0;
    logic reset, hsel, hwrite, stop_mode, pwm_counting_flag, pwm_emergency_stop;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] p0, m0, p1;
    cmpc_ticks_type ticks;
    wire logic hreadyout, hresp, reference_source_select, positive_phase_out, negative_phase_out;
    wire logic [31:0] hrdata;
    wire logic [1:0] compare_raw, comparator_on, compare_interrupt;
    wire logic [7:0] reference_level;
    logic [1:0] on_s, phase_s;
    logic [7:0] lvl_s;
    logic src_s;
    int num_errors, checks, irq_cnt, irq0_cnt;

    always #10 core_clk = ~core_clk;

    // outputs are taken mid-cycle so no check races the edge that updates them
    always @(negedge core_clk)
    begin
        on_s = comparator_on;
        lvl_s = reference_level;
        src_s = reference_source_select;
        phase_s = {positive_phase_out, negative_phase_out};
        if (compare_interrupt[1] === 1'b1)
            irq_cnt++;
        if (compare_interrupt[0] === 1'b1)
            irq0_cnt++;
    end

    cmpc_ctrl uut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compare_raw(compare_raw),
        .ticks(ticks), .stop_mode(stop_mode), .pwm_counting_flag(pwm_counting_flag),
        .pwm_emergency_stop(pwm_emergency_stop), .comparator_on(comparator_on),
        .reference_level(reference_level), .reference_source_select(reference_source_select),
        .compare_interrupt(compare_interrupt), .positive_phase_out(positive_phase_out),
        .negative_phase_out(negative_phase_out));

    cmpc_analog_model model (.core_clk(core_clk), .comparator_on(comparator_on),
        .reference_level(reference_level), .reference_source_select(reference_source_select),
        .ch0_plus_mv(p0), .ch0_minus_mv(m0), .ch1_plus_mv(p1), .compare_raw(compare_raw));

    task wrap_up;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task done(input string nm);
        $display("test %s finished, errors so far %0d", nm, num_errors);
    endtask

    // ready is judged on its settled value just before the edge that samples it
    task bus_wait;
        logic ok;
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            ok = hreadyout;
            rd = hrdata;
            n++;
            @(posedge core_clk);
        end
        while (ok !== 1'b1 && n < 20);
        if (ok !== 1'b1)
        begin
            num_errors++;
            wrap_up;
        end
    endtask

    task xfer(input logic wr_en, input logic [15:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr_en;
        haddr <= {14'h0000, idx, 2'h0};
        bus_wait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        bus_wait;
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd);
    endtask

    task rdc(input logic [15:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    task tick(input logic [2:0] t);
        ticks <= t;
        @(posedge core_clk);
        ticks <= 3'h0;
    endtask

    initial
    begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ticks = 3'h0;
        stop_mode = 1'b0;
        pwm_counting_flag = 1'b0;
        pwm_emergency_stop = 1'b0;
        p0 = 12'h000;
        m0 = 12'h000;
        p1 = 12'h000;
        num_errors = 0;
        checks = 0;
        irq_cnt = 0;
        irq0_cnt = 0;
        cyc(8);
        reset <= 1'b0;
        cyc(1);
        rdc(`CMPC_IDX_CH1_ON, 32'h0);
        rdc(`CMPC_IDX_CH1_IRQ, 32'h0);
        rdc(`CMPC_IDX_CH1_REF, 32'h8);
        chk(lvl_s, 32'h88);
        chk(hresp, 32'h0);
        rdc(16'h0F00, 32'h0);
        done("reset");
        wr(`CMPC_IDX_CH1_IRQ, 32'hFFFFFFFF);
        rdc(`CMPC_IDX_CH1_IRQ, 32'h0F);
        wr(`CMPC_IDX_CH1_REF, 32'hFFFFFFFF);
        rdc(`CMPC_IDX_CH1_REF, 32'h0F);
        chk(lvl_s[7:4], 32'hF);
        wr(`CMPC_IDX_CH0_IRQ, 32'hFF);
        rdc(`CMPC_IDX_CH0_IRQ, 32'h1F);
        chk(src_s, 32'h1);
        wr(`CMPC_IDX_CH1_ON, 32'hFE);
        rdc(`CMPC_IDX_CH1_ON, 32'h0);
        wr(`CMPC_IDX_CH0_IRQ, 32'h0);
        wr(`CMPC_IDX_CH1_IRQ, 32'h0);
        wr(`CMPC_IDX_CH1_REF, 32'h8);
        done("fields");
        p1 <= 12'h258;
        wr(`CMPC_IDX_CH1_ON, 32'h1);
        cyc(2);
        chk(on_s, 32'h2);
        cyc(20);
        rdc(`CMPC_IDX_CH1_ON, 32'h3);
        p1 <= 12'h12C;
        cyc(8);
        rdc(`CMPC_IDX_CH1_ON, 32'h1);
        wr(`CMPC_IDX_CH1_REF, 32'h0);
        cyc(8);
        rdc(`CMPC_IDX_CH1_ON, 32'h3);
        wr(`CMPC_IDX_CH1_REF, 32'hF);
        cyc(8);
        rdc(`CMPC_IDX_CH1_ON, 32'h1);
        wr(`CMPC_IDX_CH1_REF, 32'h8);
        p1 <= 12'h258;
        cyc(8);
        wr(`CMPC_IDX_CH1_ON, 32'h0);
        cyc(2);
        chk(on_s, 32'h0);
        cyc(12);
        rdc(`CMPC_IDX_CH1_ON, 32'h2);
        done("compare");
        p1 <= 12'h12C;
        wr(`CMPC_IDX_CH1_ON, 32'h1);
        cyc(20);
        for (int m = 0; m < 4; m++)
        begin
            wr(`CMPC_IDX_CH1_IRQ, m);
            irq_cnt = 0;
            p1 <= 12'h258;
            cyc(10);
            chk(irq_cnt, m >> 1);
            p1 <= 12'h12C;
            cyc(10);
            chk(irq_cnt, (m >> 1) + (m & 1));
        end
        done("edges");
        for (int s = 1; s < 4; s++)
        begin
            logic [2:0] tk;
            tk = 3'h4 >> (s - 1);
            // the fast ticks are only given while the pll is assumed running
            wr(`CMPC_IDX_CH1_IRQ, 32'h3 | (s << 2));
            tick(tk);
            cyc(4);
            irq_cnt = 0;
            p1 <= (p1 == 12'h258) ? 12'h12C : 12'h258;
            cyc(12);
            chk(irq_cnt, 32'h0);
            tick({tk[0], tk[2:1]});
            cyc(4);
            chk(irq_cnt, 32'h0);
            tick(tk);
            cyc(4);
            chk(irq_cnt, 32'h1);
        end
        irq_cnt = 0;
        // the reference is taken as kept alive by the supervisor during stop
        stop_mode <= 1'b1;
        p1 <= (p1 == 12'h258) ? 12'h12C : 12'h258;
        cyc(12);
        tick(3'h1);
        cyc(4);
        chk(irq_cnt, 32'h0);
        stop_mode <= 1'b0;
        tick(3'h1);
        cyc(4);
        chk(irq_cnt, 32'h1);
        done("sampled");
        wr(`CMPC_IDX_CH1_IRQ, 32'h0);
        p0 <= 12'h258;
        wr(`CMPC_IDX_CH0_ON, 32'h1);
        cyc(20);
        rdc(`CMPC_IDX_CH0_ON, 32'h3);
        pwm_counting_flag <= 1'b1;
        cyc(3);
        chk(phase_s, 32'h2);
        rdc(`CMPC_IDX_PWM_STAT, 32'h80);
        p0 <= 12'h12C;
        cyc(10);
        chk(phase_s, 32'h1);
        chk(irq0_cnt, 32'h0);
        pwm_counting_flag <= 1'b0;
        cyc(3);
        chk(phase_s, 32'h0);
        pwm_emergency_stop <= 1'b1;
        cyc(1);
        pwm_emergency_stop <= 1'b0;
        cyc(3);
        chk(phase_s, 32'h3);
        rdc(`CMPC_IDX_PWM_STAT, 32'h40);
        wr(`CMPC_IDX_PWM_STAT, 32'h40);
        cyc(2);
        chk(phase_s, 32'h0);
        rdc(`CMPC_IDX_PWM_STAT, 32'h0);
        done("phases");
        wrap_up;
    end
endmodule // cmpc_ctrl_test

// >>> verilog/cmpc_ctrl.sv
// comparator on/off, result hold, edge interrupts, sampling, reference and phase outputs
// Contract
// - on bit set activates a channel; cleared deactivates it
// - result reads one when plus input exceeds minus input, else zero
// - switching a channel off freezes its result, still readable
// - channel 1 result at bit 1 compares external input against reference
// - edge field bits 1:0: off, falling, rising, both; resets to 00
// - interrupt raised on each result transition matching edge mode; when sampled, on a tick where result differs from the last sample
// - sample field bits 3:2: none, 16 kHz, 128 kHz, 256 kHz ticks
// - in stop mode no sampled detection happens
// - four-bit reference level, 50 mV steps, resets to 1000
// - channel 0 phase outputs follow the PWM counting flag
// - PWM emergency stop forces both phase outputs high
// - writing one to emergency flag clears it and drives phases low
// - channel 1 register 0: on at bit 0, result at bit 1, resets zero
`timescale 1ns/1ps
`include "cmpc_regs.svh"

module cmpc_ctrl (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] compare_raw,
    input wire cmpc_pkg::cmpc_ticks_type ticks,
    input wire logic stop_mode,
    input wire logic pwm_counting_flag,
    input wire logic pwm_emergency_stop,
    output logic [1:0] comparator_on,
    output logic [7:0] reference_level,
    output logic reference_source_select,
    output logic [1:0] compare_interrupt,
    output logic positive_phase_out,
    output logic negative_phase_out
);
    import cmpc_pkg::*;

    // a macro literal cannot be bit-selected directly, so it is held at its width first
    localparam logic [7:0] on_rst_val = `CMPC_ON_RESET;
    localparam logic [7:0] irq_rst_val = `CMPC_IRQ_RESET;

    cmpc_bus_type bus_ff;
    cmpc_bus_type nxt_bus;
    logic [31:0] addr_ff;
    logic [31:0] hrdata_ff;
    cmpc_cfg_type cfg_ff [1:0];
    logic [1:0] result_ff;
    logic estop_flag_ff;
    logic hold_high_ff;
    logic pos_ff;
    logic neg_ff;
    logic [1:0] irq_ff;
    logic accept;
    logic wr_en;
    logic [1:0] wr_chan;
    cmpc_sel_type wr_sel;
    logic estop_clear;

    // which register a word address hits; also reports the channel
    function automatic cmpc_sel_type reg_decode(input logic [31:0] a, output logic [1:0] ch);
        logic [15:0] idx;
        idx = a[17:2];
        ch = 2'h0;
        reg_decode = SEL_NONE;
        if (a[31:18] == 14'h0000 && a[1:0] == 2'h0)
        begin
            case (idx)
                `CMPC_IDX_CH0_ON: reg_decode = SEL_ON;
                `CMPC_IDX_CH0_IRQ: reg_decode = SEL_IRQ;
                `CMPC_IDX_CH0_REF: reg_decode = SEL_REF;
                `CMPC_IDX_CH1_ON:
                begin
                    reg_decode = SEL_ON;
                    ch = 2'h1;
                end
                `CMPC_IDX_CH1_IRQ:
                begin
                    reg_decode = SEL_IRQ;
                    ch = 2'h1;
                end
                `CMPC_IDX_CH1_REF:
                begin
                    reg_decode = SEL_REF;
                    ch = 2'h1;
                end
                `CMPC_IDX_PWM_STAT: reg_decode = SEL_PWM;
                default: reg_decode = SEL_NONE;
            endcase
        end
    endfunction

    // tick chosen by the sample field; stop mode halts every tick
    function automatic logic tick_pick(input cmpc_sample_type m, input cmpc_ticks_type t,
                                       input logic stopped);
        case (m)
            SMP_16K: tick_pick = t.tick_16k && !stopped;
            SMP_128K: tick_pick = t.tick_128k && !stopped;
            SMP_256K: tick_pick = t.tick_256k && !stopped;
            default: tick_pick = 1'b0;
        endcase
    endfunction

    // bus slave: writes have no wait state, reads one so that read data is registered
    assign accept = hsel && htrans[1] && hready;
    assign hreadyout = (bus_ff != BUS_RWAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_comb
    begin
        case (bus_ff)
            BUS_RWAIT: nxt_bus = BUS_RDATA;
            default: nxt_bus = accept ? (hwrite ? BUS_WDATA : BUS_RWAIT) : BUS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            bus_ff <= BUS_IDLE;
            addr_ff <= 32'h0000_0000;
        end
        else
        begin
            bus_ff <= nxt_bus;
            if (accept)
            begin
                addr_ff <= haddr;
            end
        end
    end

    always_comb
    begin
        wr_chan = 2'h0;
        wr_sel = reg_decode(addr_ff, wr_chan);
        wr_en = (bus_ff == BUS_WDATA);
    end

    assign estop_clear = wr_en && wr_sel == SEL_PWM && hwdata[`CMPC_ESTOP_BIT];

    // read data; bits above each register's fields stay zero
    always_ff @(posedge core_clk)
    begin
        logic [1:0] rch;
        cmpc_sel_type rsel;
        rch = 2'h0;
        rsel = reg_decode(addr_ff, rch);
        if (reset)
        begin
            hrdata_ff <= 32'h0000_0000;
        end
        else if (bus_ff == BUS_RWAIT)
        begin
            hrdata_ff <= 32'h0000_0000;
            case (rsel)
                SEL_ON:
                begin
                    hrdata_ff[`CMPC_ON_BIT] <= cfg_ff[rch[0]].on;
                    hrdata_ff[`CMPC_RESULT_BIT] <= result_ff[rch[0]];
                end
                SEL_IRQ:
                begin
                    hrdata_ff[`CMPC_EDGE_LSB+:2] <= cfg_ff[rch[0]].edge_mode;
                    hrdata_ff[`CMPC_SAMPLE_LSB+:2] <= cfg_ff[rch[0]].sample_mode;
                    hrdata_ff[`CMPC_REFSRC_BIT] <= cfg_ff[rch[0]].ref_source && !rch[0];
                end
                SEL_REF: hrdata_ff[3:0] <= cfg_ff[rch[0]].ref_level;
                SEL_PWM:
                begin
                    hrdata_ff[`CMPC_COUNTING_BIT] <= pwm_counting_flag;
                    hrdata_ff[`CMPC_ESTOP_BIT] <= estop_flag_ff;
                end
                default: hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    genvar n;
    generate
        for (n = 0; n < 2; n++)
        begin : g_chan
            logic [2:0] sync_ff;
            logic res_d_ff;
            logic smp_ff;
            logic rise;
            logic fall;
            logic tick_sel;

            // configuration registers of this channel
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    cfg_ff[n].on <= on_rst_val[`CMPC_ON_BIT];
                    cfg_ff[n].edge_mode <= EDGE_OFF;
                    cfg_ff[n].sample_mode <= SMP_NONE;
                    cfg_ff[n].ref_source <= irq_rst_val[`CMPC_REFSRC_BIT];
                    cfg_ff[n].ref_level <= `CMPC_REF_RESET;
                end
                else if (wr_en && wr_chan == 2'(n))
                begin
                    case (wr_sel)
                        SEL_ON: cfg_ff[n].on <= hwdata[`CMPC_ON_BIT];
                        SEL_IRQ:
                        begin
                            cfg_ff[n].edge_mode <= cmpc_edge_type'(hwdata[`CMPC_EDGE_LSB+:2]);
                            cfg_ff[n].sample_mode <=
                                cmpc_sample_type'(hwdata[`CMPC_SAMPLE_LSB+:2]);
                            // channel 1 has no external reference, its source bit is fixed
                            cfg_ff[n].ref_source <= (n == 0) && hwdata[`CMPC_REFSRC_BIT];
                        end
                        SEL_REF: cfg_ff[n].ref_level <= hwdata[3:0];
                        default: cfg_ff[n].ref_level <= cfg_ff[n].ref_level;
                    endcase
                end
            end

            // the analog output is asynchronous; three stages, change once the last two agree
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    sync_ff <= 3'h0;
                end
                else
                begin
                    sync_ff <= {sync_ff[1:0], compare_raw[n]};
                end
            end

            // the result only follows the comparator while on, so it freezes when off
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    result_ff[n] <= 1'b0;
                end
                else if (cfg_ff[n].on && sync_ff[1] == sync_ff[2])
                begin
                    result_ff[n] <= sync_ff[2];
                end
            end

            assign tick_sel = tick_pick(cfg_ff[n].sample_mode, ticks, stop_mode);

            // outside sampled mode the sample tracks the result so entering it is clean
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    res_d_ff <= 1'b0;
                    smp_ff <= 1'b0;
                end
                else
                begin
                    res_d_ff <= result_ff[n];
                    if (cfg_ff[n].sample_mode == SMP_NONE || tick_sel)
                    begin
                        smp_ff <= result_ff[n];
                    end
                end
            end

            always_comb
            begin
                if (cfg_ff[n].sample_mode == SMP_NONE)
                begin
                    rise = result_ff[n] && !res_d_ff;
                    fall = !result_ff[n] && res_d_ff;
                end
                else
                begin
                    rise = tick_sel && result_ff[n] && !smp_ff;
                    fall = tick_sel && !result_ff[n] && smp_ff;
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    irq_ff[n] <= 1'b0;
                end
                else
                begin
                    case (cfg_ff[n].edge_mode)
                        EDGE_FALL: irq_ff[n] <= fall;
                        EDGE_RISE: irq_ff[n] <= rise;
                        EDGE_BOTH: irq_ff[n] <= rise || fall;
                        default: irq_ff[n] <= 1'b0;
                    endcase
                end
            end

            sequence raw_held_high;
                (compare_raw[n] && cfg_ff[n].on)[*5];
            endsequence

            chk_sync_result_path: assert property (@(posedge core_clk) disable iff (reset)
                raw_held_high |-> result_ff[n])
                else $error("result did not follow a steady comparator output");
            chk_off_result_frozen: assert property (@(posedge core_clk) disable iff (reset)
                !cfg_ff[n].on |=> $stable(result_ff[n]))
                else $error("result changed while channel off");
            chk_irq_disabled: assert property (@(posedge core_clk) disable iff (reset)
                cfg_ff[n].edge_mode == EDGE_OFF |=> !irq_ff[n])
                else $error("interrupt raised in disabled mode");
            chk_irq_rise_edge: assert property (@(posedge core_clk) disable iff (reset)
                (cfg_ff[n].edge_mode == EDGE_RISE && cfg_ff[n].sample_mode == SMP_NONE
                 && $rose(result_ff[n])) |=> irq_ff[n])
                else $error("rising edge did not raise interrupt");
            chk_stop_no_sample: assert property (@(posedge core_clk) disable iff (reset)
                (stop_mode && cfg_ff[n].sample_mode != SMP_NONE) |=> !irq_ff[n])
                else $error("sampled interrupt during stop mode");
            chk_sampled_tick_only: assert property (@(posedge core_clk) disable iff (reset)
                (cfg_ff[n].sample_mode != SMP_NONE && !tick_sel) |=> !irq_ff[n])
                else $error("sampled interrupt without a tick");
        end
    endgenerate

    // emergency flag: an arriving stop wins over a same-cycle clear
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            estop_flag_ff <= 1'b0;
            hold_high_ff <= 1'b0;
        end
        else if (pwm_emergency_stop)
        begin
            estop_flag_ff <= 1'b1;
            hold_high_ff <= 1'b1;
        end
        else if (estop_clear)
        begin
            estop_flag_ff <= 1'b0;
            hold_high_ff <= 1'b0;
        end
    end

    // phase outputs follow the channel 0 result only while the PWM counts
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
        end
        else if (pwm_emergency_stop || (hold_high_ff && !estop_clear))
        begin
            pos_ff <= 1'b1;
            neg_ff <= 1'b1;
        end
        else if (estop_clear)
        begin
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
        end
        else
        begin
            pos_ff <= pwm_counting_flag && result_ff[0];
            neg_ff <= pwm_counting_flag && !result_ff[0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            compare_interrupt <= 2'h0;
        end
        else
        begin
            compare_interrupt <= irq_ff;
        end
    end

    assign comparator_on = {cfg_ff[1].on, cfg_ff[0].on};
    assign reference_level = {cfg_ff[1].ref_level, cfg_ff[0].ref_level};
    assign reference_source_select = cfg_ff[0].ref_source;
    assign positive_phase_out = pos_ff;
    assign negative_phase_out = neg_ff;

    chk_on_write_applies: assert property (@(posedge core_clk) disable iff (reset)
        (wr_en && wr_sel == SEL_ON && wr_chan == 2'h1)
        |=> comparator_on[1] == $past(hwdata[`CMPC_ON_BIT]))
        else $error("on bit write not applied");
    chk_ref_after_reset: assert property (@(posedge core_clk) disable iff (reset)
        $fell(reset) |-> reference_level == {`CMPC_REF_RESET, `CMPC_REF_RESET})
        else $error("reference level reset value wrong");
    chk_read_upper_zero: assert property (@(posedge core_clk) disable iff (reset)
        bus_ff == BUS_RDATA |-> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_estop_forces_high: assert property (@(posedge core_clk) disable iff (reset)
        (pwm_emergency_stop ##1 !estop_clear) |=> positive_phase_out && negative_phase_out)
        else $error("phase outputs not high after emergency stop");
    chk_estop_clear_low: assert property (@(posedge core_clk) disable iff (reset)
        (estop_clear && !pwm_emergency_stop)
        |=> !estop_flag_ff && !positive_phase_out && !negative_phase_out)
        else $error("emergency clear did not drive phases low");
    chk_phase_idle_low: assert property (@(posedge core_clk) disable iff (reset)
        (!pwm_counting_flag && !hold_high_ff && !pwm_emergency_stop) |=> !positive_phase_out)
        else $error("phase output high while pwm idle");

endmodule // cmpc_ctrl

// >>> verilog/cmpc_pkg.sv
// types shared by the comparator control block
package cmpc_pkg;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } cmpc_edge_type;

    typedef enum logic [1:0] {
        SMP_NONE = 2'b00,
        SMP_16K = 2'b01,
        SMP_128K = 2'b10,
        SMP_256K = 2'b11
    } cmpc_sample_type;

    // gray codes along idle -> read wait -> read data
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RWAIT = 2'b01,
        BUS_RDATA = 2'b11,
        BUS_WDATA = 2'b10
    } cmpc_bus_type;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_ON = 3'h1,
        SEL_IRQ = 3'h2,
        SEL_REF = 3'h3,
        SEL_PWM = 3'h4
    } cmpc_sel_type;

    typedef struct packed {
        logic on;
        cmpc_edge_type edge_mode;
        cmpc_sample_type sample_mode;
        logic ref_source;
        logic [3:0] ref_level;
    } cmpc_cfg_type;

    typedef struct packed {
        logic tick_16k;
        logic tick_128k;
        logic tick_256k;
    } cmpc_ticks_type;

endpackage

// >>> verilog/cmpc_regs.svh
// register indices, field positions, reset values for the comparator control block
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define CMPC_IDX_CH0_ON 16'hF950
`define CMPC_IDX_CH0_IRQ 16'hF951
`define CMPC_IDX_CH0_REF 16'hF952
`define CMPC_IDX_CH1_ON 16'hF954
`define CMPC_IDX_CH1_IRQ 16'hF955
`define CMPC_IDX_CH1_REF 16'hF956
`define CMPC_IDX_PWM_STAT 16'hF958

`define CMPC_ON_BIT 0
`define CMPC_RESULT_BIT 1
`define CMPC_EDGE_LSB 0
`define CMPC_SAMPLE_LSB 2
`define CMPC_REFSRC_BIT 4
`define CMPC_ESTOP_BIT 6
`define CMPC_COUNTING_BIT 7

`define CMPC_ON_RESET 8'h00
`define CMPC_IRQ_RESET 8'h00
`define CMPC_REF_RESET 4'h8

`endif
